// *** src/sram_pkg.sv ***
// Shared constants and types for the pipelined burst synchronous memory
package sram_pkg;

	localparam int ADDR_W = 17;
	localparam int HI_W = 15;
	localparam int LOW_W = 2;
	localparam int DATA_W = 36;
	localparam int LANE_CNT = 4;
	localparam int LANE_W = 9;
	localparam int WORDS = 131072;
	localparam int POST_DEPTH = 32;

	localparam logic [LOW_W-1:0] CNT_RST = 2'h0;
	localparam logic [LOW_W-1:0] CNT_STEP = 2'h1;
	localparam logic [HI_W-1:0] HI_RST = 15'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
	localparam logic [LANE_CNT-1:0] LANES_ALL = 4'hf;
	localparam logic [LANE_CNT-1:0] LANES_NONE = 4'h0;

	typedef enum {ST_DESELECTED, ST_BURST} burst_state_type;

	// Snapshot of every clocked pin except the order select, taken at each rising edge
	typedef struct packed {
		logic [HI_W-1:0] hi;
		logic [LOW_W-1:0] low;
		logic proc_strobe_n;
		logic ctrl_strobe_n;
		logic advance_n;
		logic ce_primary_n;
		logic ce_high;
		logic ce_third_n;
		logic [LANE_CNT-1:0] lane_write_n;
		logic all_lanes_write_n;
		logic write_enable_n;
		logic [DATA_W-1:0] data;
	} pin_sample_type;

	// One posted write waiting for the array
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LANE_CNT-1:0] lanes;
		logic [DATA_W-1:0] data;
	} post_entry_type;

endpackage : sram_pkg

// *** src/sram_array.sv ***
// Single-port word array with lane write strobes and registered read data
`timescale 1ns/10ps
module sram_array #(
	parameter int WORDS = 131072,
	parameter int ADDR_W = 17,
	parameter int LANE_CNT = 4,
	parameter int LANE_W = 9
) (
	// Clock
	input wire logic clk_in,
	// Access port
	input wire logic en_in,
	input wire logic we_in,
	input wire logic [LANE_CNT-1:0] lanes_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [LANE_CNT*LANE_W-1:0] wdata_in,
	output logic [LANE_CNT*LANE_W-1:0] rdata_out
);

	logic [LANE_CNT*LANE_W-1:0] mem [0:WORDS-1];

	genvar g;
	generate
		for (g = 0; g < LANE_CNT; g++) begin : lane_gen
			always_ff @(posedge clk_in) begin
				if (en_in && we_in && lanes_in[g]) begin
					mem[addr_in][g*LANE_W +: LANE_W] <= wdata_in[g*LANE_W +: LANE_W];
				end
			end
		end
	endgenerate

	// Read port holds its last word when not enabled
	always_ff @(posedge clk_in) begin
		if (en_in && !we_in) begin
			rdata_out <= mem[addr_in];
		end
	end

endmodule : sram_array

// *** src/post_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a registered full flag
`timescale 1ns/10ps
module post_fifo #(
	parameter int WIDTH = 57,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [PTR_W:0] count_reg, count_next;
	logic not_full_reg, not_full_next;
	logic push, pop;

	always_comb begin
		push = in_valid_in && not_full_reg;
		pop = (count_reg != '0) && out_ready_in;
		wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
		count_next = count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		not_full_next = count_next != (PTR_W+1)'(DEPTH);
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			not_full_reg <= 1'b1;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
			not_full_reg <= not_full_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			store[wr_ptr_reg] <= in_data_in;
		end
	end

	assign in_ready_out = not_full_reg;
	assign out_valid_out = count_reg != '0;
	assign out_data_out = store[rd_ptr_reg];

endmodule : post_fifo

// *** src/pipelined_burst_sync_sram.sv ***
// Pipelined burst synchronous memory: input capture, burst counter, posted writes
`timescale 1ns/10ps
module pipelined_burst_sync_sram (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Address
	input wire logic [sram_pkg::HI_W-1:0] addr_in,
	input wire logic addr_low_bit1_in,
	input wire logic addr_low_bit0_in,
	// Burst control
	input wire logic proc_addr_strobe_n_in,
	input wire logic ctrl_addr_strobe_n_in,
	input wire logic burst_advance_n_in,
	input wire logic burst_order_sel_in,
	// Chip enables
	input wire logic chip_enable_primary_n_in,
	input wire logic chip_enable_high_in,
	input wire logic chip_enable_third_n_in,
	// Write control
	input wire logic [sram_pkg::LANE_CNT-1:0] lane_write_n_in,
	input wire logic all_lanes_write_n_in,
	input wire logic write_enable_n_in,
	output logic write_post_ready_out,
	// Data pins, split into in, out and enable
	input wire logic [sram_pkg::DATA_W-1:0] byte_lane_data_in,
	output logic [sram_pkg::DATA_W-1:0] byte_lane_data_out,
	output logic byte_lane_data_oe_out,
	input wire logic output_enable_n_in
);

	// Burst address low bits in the selected order
	function automatic logic [sram_pkg::LOW_W-1:0] burst_low(
		input logic [sram_pkg::LOW_W-1:0] start,
		input logic [sram_pkg::LOW_W-1:0] cnt,
		input logic interleaved
	);
		if (interleaved) begin
			burst_low = start ^ cnt;
		end else begin
			burst_low = start + cnt;
		end
	endfunction : burst_low

	// Lanes selected by the write controls of one sample
	function automatic logic [sram_pkg::LANE_CNT-1:0] write_lanes(
		input sram_pkg::pin_sample_type s
	);
		if (!s.all_lanes_write_n) begin
			write_lanes = sram_pkg::LANES_ALL;
		end else if (!s.write_enable_n) begin
			write_lanes = ~s.lane_write_n;
		end else begin
			write_lanes = sram_pkg::LANES_NONE;
		end
	endfunction : write_lanes

	// Word from the array with the lanes of a queued write laid over it
	function automatic logic [sram_pkg::DATA_W-1:0] merge_lanes(
		input logic [sram_pkg::DATA_W-1:0] old_word,
		input logic [sram_pkg::DATA_W-1:0] new_word,
		input logic [sram_pkg::LANE_CNT-1:0] sel
	);
		merge_lanes = old_word;
		for (int i = 0; i < sram_pkg::LANE_CNT; i++) begin
			if (sel[i]) begin
				merge_lanes[i*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
					new_word[i*sram_pkg::LANE_W +: sram_pkg::LANE_W];
			end
		end
	endfunction : merge_lanes

	// Input registers
	sram_pkg::pin_sample_type sample_reg, sample_next;
	// Order select is a static strap; two stages keep a late change clean
	logic order_meta_reg, order_meta_next;
	logic order_reg, order_next;

	// Burst state
	sram_pkg::burst_state_type state_reg, state_next;
	logic [sram_pkg::HI_W-1:0] hi_reg, hi_next;
	logic [sram_pkg::LOW_W-1:0] start_reg, start_next;
	logic [sram_pkg::LOW_W-1:0] cnt_reg, cnt_next;

	// Output pipeline
	logic rd_pend_reg, rd_pend_next;
	logic drive_reg, drive_next;
	logic [sram_pkg::DATA_W-1:0] dout_reg, dout_next;
	// Lanes of a queued write that the array has not taken yet
	logic fwd_hit_reg, fwd_hit_next;
	logic [sram_pkg::LANE_CNT-1:0] fwd_lanes_reg, fwd_lanes_next;
	logic [sram_pkg::DATA_W-1:0] fwd_data_reg, fwd_data_next;

	// Cycle decode
	logic selected;
	logic access;
	logic is_write;
	logic rd_issue;
	logic [sram_pkg::LANE_CNT-1:0] lanes;
	logic [sram_pkg::ADDR_W-1:0] acc_addr;

	// Posting FIFO and array wiring
	sram_pkg::post_entry_type post_in, post_out;
	logic post_valid, post_drain;
	logic mem_en, mem_we;
	logic [sram_pkg::LANE_CNT-1:0] mem_lanes;
	logic [sram_pkg::ADDR_W-1:0] mem_addr;
	logic [sram_pkg::DATA_W-1:0] mem_wdata, mem_rdata;

	always_comb begin
		sample_next.hi = addr_in;
		sample_next.low = {addr_low_bit1_in, addr_low_bit0_in};
		sample_next.proc_strobe_n = proc_addr_strobe_n_in;
		sample_next.ctrl_strobe_n = ctrl_addr_strobe_n_in;
		sample_next.advance_n = burst_advance_n_in;
		sample_next.ce_primary_n = chip_enable_primary_n_in;
		sample_next.ce_high = chip_enable_high_in;
		sample_next.ce_third_n = chip_enable_third_n_in;
		sample_next.lane_write_n = lane_write_n_in;
		sample_next.all_lanes_write_n = all_lanes_write_n_in;
		sample_next.write_enable_n = write_enable_n_in;
		sample_next.data = byte_lane_data_in;
		order_meta_next = burst_order_sel_in;
		order_next = order_meta_reg;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			// Strobes and enables idle so no access starts from reset
			sample_reg <= '0;
			sample_reg.proc_strobe_n <= 1'b1;
			sample_reg.ctrl_strobe_n <= 1'b1;
			sample_reg.advance_n <= 1'b1;
			sample_reg.ce_primary_n <= 1'b1;
			sample_reg.ce_third_n <= 1'b1;
			sample_reg.lane_write_n <= sram_pkg::LANES_ALL;
			sample_reg.all_lanes_write_n <= 1'b1;
			sample_reg.write_enable_n <= 1'b1;
		end else begin
			sample_reg <= sample_next;
		end
		// Not reset, so the strap has settled by the time reset lifts
		order_meta_reg <= order_meta_next;
		order_reg <= order_next;
	end

	// Next burst state and this cycle's access
	always_comb begin
		selected = !sample_reg.ce_primary_n && sample_reg.ce_high
			&& !sample_reg.ce_third_n;
		lanes = write_lanes(sample_reg);
		state_next = state_reg;
		hi_next = hi_reg;
		start_next = start_reg;
		cnt_next = cnt_reg;
		access = 1'b0;
		is_write = 1'b0;
		if (!sample_reg.proc_strobe_n && !sample_reg.ce_primary_n) begin
			// Processor strobe reads when selected, else deselects; write controls ignored
			if (selected) begin
				state_next = sram_pkg::ST_BURST;
				hi_next = sample_reg.hi;
				start_next = sample_reg.low;
				cnt_next = sram_pkg::CNT_RST;
				access = 1'b1;
			end else begin
				state_next = sram_pkg::ST_DESELECTED;
			end
		end else if (!sample_reg.ctrl_strobe_n) begin
			if (selected) begin
				state_next = sram_pkg::ST_BURST;
				hi_next = sample_reg.hi;
				start_next = sample_reg.low;
				cnt_next = sram_pkg::CNT_RST;
				access = 1'b1;
				is_write = lanes != sram_pkg::LANES_NONE;
			end else begin
				state_next = sram_pkg::ST_DESELECTED;
			end
		end else begin
			case (state_reg)
				sram_pkg::ST_BURST: begin
					access = 1'b1;
					is_write = lanes != sram_pkg::LANES_NONE;
					if (!sample_reg.advance_n) begin
						cnt_next = cnt_reg + sram_pkg::CNT_STEP;
					end
				end
				sram_pkg::ST_DESELECTED: begin
					access = 1'b0;
				end
				default: begin
					state_next = sram_pkg::ST_DESELECTED;
				end
			endcase
		end
		acc_addr = {hi_next, burst_low(start_next, cnt_next, order_reg)};
		rd_issue = access && !is_write;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_reg <= sram_pkg::ST_DESELECTED;
			hi_reg <= sram_pkg::HI_RST;
			start_reg <= sram_pkg::CNT_RST;
			cnt_reg <= sram_pkg::CNT_RST;
		end else begin
			state_reg <= state_next;
			hi_reg <= hi_next;
			start_reg <= start_next;
			cnt_reg <= cnt_next;
		end
	end

	// Writes are posted and land in the array on a later idle slot
	// Every non-read cycle drains, so at most one write waits at a time
	always_comb begin
		post_in.addr = acc_addr;
		post_in.lanes = lanes;
		post_in.data = sample_reg.data;
		post_valid = access && is_write;
		post_drain = !rd_issue;
		mem_en = rd_issue || post_drain;
		mem_we = !rd_issue;
		mem_lanes = post_out.lanes;
		mem_addr = rd_issue ? acc_addr : post_out.addr;
		mem_wdata = post_out.data;
	end

	logic post_out_valid;

	post_fifo #(
		.WIDTH($bits(sram_pkg::post_entry_type)),
		.DEPTH(sram_pkg::POST_DEPTH)
	) post_fifo_inst (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.in_valid_in(post_valid),
		.in_ready_out(write_post_ready_out),
		.in_data_in(post_in),
		.out_valid_out(post_out_valid),
		.out_ready_in(post_drain),
		.out_data_out(post_out)
	);

	// Reads take the array first; a queued write waits for the next free slot
	sram_array #(
		.WORDS(sram_pkg::WORDS),
		.ADDR_W(sram_pkg::ADDR_W),
		.LANE_CNT(sram_pkg::LANE_CNT),
		.LANE_W(sram_pkg::LANE_W)
	) array_inst (
		.clk_in(clk_in),
		.en_in(mem_en && (rd_issue || post_out_valid)),
		.we_in(mem_we),
		.lanes_in(mem_lanes),
		.addr_in(mem_addr),
		.wdata_in(mem_wdata),
		.rdata_out(mem_rdata)
	);

	// Output register: array word one edge later, pins the edge after
	always_comb begin
		rd_pend_next = rd_issue;
		drive_next = rd_pend_reg;
		// Queued write to the word being read, caught before the array sees it
		fwd_hit_next = rd_issue && post_out_valid
			&& post_out.addr == acc_addr;
		fwd_lanes_next = post_out.lanes;
		fwd_data_next = post_out.data;
		if (!rd_pend_reg) begin
			dout_next = dout_reg;
		end else if (fwd_hit_reg) begin
			dout_next = merge_lanes(mem_rdata, fwd_data_reg, fwd_lanes_reg);
		end else begin
			dout_next = mem_rdata;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rd_pend_reg <= 1'b0;
			drive_reg <= 1'b0;
			dout_reg <= sram_pkg::DATA_RST;
			fwd_hit_reg <= 1'b0;
			fwd_lanes_reg <= sram_pkg::LANES_NONE;
			fwd_data_reg <= sram_pkg::DATA_RST;
		end else begin
			rd_pend_reg <= rd_pend_next;
			drive_reg <= drive_next;
			dout_reg <= dout_next;
			fwd_hit_reg <= fwd_hit_next;
			fwd_lanes_reg <= fwd_lanes_next;
			fwd_data_reg <= fwd_data_next;
		end
	end

	assign byte_lane_data_out = dout_reg;
	// Enable pin is asynchronous, so it gates the registered drive directly
	assign byte_lane_data_oe_out = drive_reg && !output_enable_n_in;

endmodule : pipelined_burst_sync_sram

// *** verification/sram_chk.sv ***
// Pin-level checks for the pipelined burst memory
`timescale 1ns/10ps
module sram_chk (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Watched inputs
	input wire logic proc_addr_strobe_n_in,
	input wire logic ctrl_addr_strobe_n_in,
	input wire logic burst_advance_n_in,
	input wire logic chip_enable_primary_n_in,
	input wire logic chip_enable_high_in,
	input wire logic chip_enable_third_n_in,
	input wire logic [sram_pkg::LANE_CNT-1:0] lane_write_n_in,
	input wire logic all_lanes_write_n_in,
	input wire logic write_enable_n_in,
	input wire logic output_enable_n_in,
	// Watched outputs
	input wire logic [sram_pkg::DATA_W-1:0] byte_lane_data_out,
	input wire logic byte_lane_data_oe_out,
	input wire logic write_post_ready_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	logic sel, wr, susp, cst, drv;
	assign sel = !chip_enable_primary_n_in && chip_enable_high_in && !chip_enable_third_n_in;
	assign wr = !all_lanes_write_n_in || (!write_enable_n_in && lane_write_n_in != 4'hf);
	assign susp = proc_addr_strobe_n_in && ctrl_addr_strobe_n_in && burst_advance_n_in;
	assign cst = proc_addr_strobe_n_in && !ctrl_addr_strobe_n_in;
	assign drv = byte_lane_data_oe_out;
	a_float_when_off: assert property (output_enable_n_in |-> !drv)
		else $error("pins driven with output enable off");
	a_proc_read_drives: assert property (!proc_addr_strobe_n_in && sel
		|-> ##3 (output_enable_n_in || drv))
		else $error("processor read gave no data");
	a_ctrl_read_drives: assert property (cst && sel && !wr
		|-> ##3 (output_enable_n_in || drv))
		else $error("controller read gave no data");
	a_write_floats: assert property (cst && sel && wr |-> ##3 !drv)
		else $error("write cycle drove the pins");
	a_deselect_floats: assert property (cst && !sel |-> ##3 !drv)
		else $error("deselect drove the pins");
	a_reset_clears: assert property (disable iff (1'b0) sys_rst_in
		|=> !drv && byte_lane_data_out == 36'h0 && write_post_ready_out)
		else $error("reset left outputs set");
	a_idle_holds_data: assert property (!output_enable_n_in && !drv
		|-> $stable(byte_lane_data_out))
		else $error("read data changed without a read");
	a_suspend_repeats: assert property (susp ##2 drv ##1 drv
		|-> $stable(byte_lane_data_out))
		else $error("suspend changed the word");
	cover property (susp ##2 drv ##1 drv);
	cover property (cst && sel && wr);
	cover property (!proc_addr_strobe_n_in && sel);
endmodule : sram_chk

// *** verification/host_model.sv ***
// Cache controller model driving the burst bus one command per cycle
`timescale 1ns/10ps
module host_model (
	// Bus toward the memory
	output logic [16:0] addr_out,
	output logic proc_n_out,
	output logic ctrl_n_out,
	output logic adv_n_out,
	output logic order_out,
	output logic [2:0] ce_out,
	output logic [3:0] lane_n_out,
	output logic gw_n_out,
	output logic we_n_out,
	output logic [35:0] data_out,
	output logic oe_n_out
);
	logic oe_off = 1'b0;
	logic [35:0] last = 36'h0;
	// Kinds: 0 deselect, 1 proc read, 2 ctrl read, 3 write, 4 advance, 5 suspend,
	// 6 processor strobe while primary enable is high
	task cyc(input int k, input logic [16:0] a, input logic [35:0] d,
		input logic [3:0] ln, input logic gw, input logic we);
		addr_out = a;
		proc_n_out = !(k == 1 || k == 6);
		ctrl_n_out = !(k == 0 || k == 2 || k == 3);
		adv_n_out = (k != 4);
		ce_out = (k == 0 || k == 6) ? 3'h6 : 3'h2;
		lane_n_out = (k == 3) ? ln : 4'hf;
		gw_n_out = (k == 3) ? gw : 1'b1;
		we_n_out = (k == 3) ? we : 1'b1;
		// Released lines toggle so a stale sample never matches
		last = (k == 3) ? d : ~last;
		data_out = last;
		oe_n_out = oe_off || k == 3;
	endtask : cyc
	// Only called while the bench holds reset
	task setord(input logic o);
		order_out = o;
	endtask : setord
	initial begin
		order_out = 1'b0;
		cyc(0, 17'h0, 36'h0, 4'hf, 1'b1, 1'b1);
	end
endmodule : host_model

// *** verification/tb_top.sv ***
// Self-checking bench for the pipelined burst memory
`timescale 1ns/10ps
module tb_top;
	logic clk_in = 1'b0;
	logic sys_rst_in;
	logic [14:0] addr_in;
	logic addr_low_bit1_in, addr_low_bit0_in, proc_addr_strobe_n_in, ctrl_addr_strobe_n_in;
	logic burst_advance_n_in, burst_order_sel_in, chip_enable_primary_n_in;
	logic chip_enable_high_in, chip_enable_third_n_in, all_lanes_write_n_in;
	logic write_enable_n_in, write_post_ready_out, byte_lane_data_oe_out, output_enable_n_in;
	logic [3:0] lane_write_n_in;
	logic [35:0] byte_lane_data_in, byte_lane_data_out, hd;
	int fails = 0;
	int total_checks = 0;
	logic pd[3] = '{default: 1'b0};
	logic [35:0] px[3];
	always #5 clk_in = ~clk_in;
	assign byte_lane_data_in = (byte_lane_data_oe_out === 1'b1) ? byte_lane_data_out : hd;
	host_model i_host_model (.addr_out({addr_in, addr_low_bit1_in, addr_low_bit0_in}),
		.proc_n_out(proc_addr_strobe_n_in), .ctrl_n_out(ctrl_addr_strobe_n_in),
		.adv_n_out(burst_advance_n_in), .order_out(burst_order_sel_in),
		.ce_out({chip_enable_primary_n_in, chip_enable_high_in, chip_enable_third_n_in}),
		.lane_n_out(lane_write_n_in), .gw_n_out(all_lanes_write_n_in),
		.we_n_out(write_enable_n_in), .data_out(hd), .oe_n_out(output_enable_n_in));
	pipelined_burst_sync_sram i_pipelined_burst_sync_sram (.clk_in, .sys_rst_in, .addr_in,
		.addr_low_bit1_in, .addr_low_bit0_in, .proc_addr_strobe_n_in, .ctrl_addr_strobe_n_in,
		.burst_advance_n_in, .burst_order_sel_in, .chip_enable_primary_n_in,
		.chip_enable_high_in, .chip_enable_third_n_in, .lane_write_n_in, .all_lanes_write_n_in,
		.write_enable_n_in, .write_post_ready_out, .byte_lane_data_in, .byte_lane_data_out,
		.byte_lane_data_oe_out, .output_enable_n_in);
	task chk_bit(input logic g, input logic e, input string m);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk_bit
	task chk_word(input logic [35:0] g, input logic [35:0] e, input string m);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: %s %h", $time, m, g);
		end
	endtask : chk_word
	function logic [35:0] word(input logic [16:0] a);
		return {a, ~a, 2'h1};
	endfunction : word
	function logic [16:0] baddr(input logic [1:0] s, input logic [1:0] c, input logic o);
		return {15'h8, o ? s ^ c : s + c};
	endfunction : baddr
	// Output of each command is judged three steps after it was issued
	task step(input int k, input logic [16:0] a, input logic [35:0] d, input logic e,
		input logic [35:0] x, input logic [3:0] l = 4'hf, input logic g = 1'b1,
		input logic w = 1'b1);
		@(negedge clk_in);
		chk_bit(byte_lane_data_oe_out, pd[2], "drive");
		if (pd[2])
			chk_word(byte_lane_data_out, px[2], "read word");
		for (int i = 2; i > 0; i--) begin
			pd[i] = pd[i-1];
			px[i] = px[i-1];
		end
		pd[0] = e;
		px[0] = x;
		i_host_model.cyc(k, a, d, l, g, w);
	endtask : step
	task idle(input int n);
		repeat (n) step(0, 17'h0, 36'h0, 1'b0, 36'h0);
	endtask : idle
	task do_reset(input logic o);
		sys_rst_in = 1'b1;
		i_host_model.setord(o);
		repeat (4) @(negedge clk_in);
		sys_rst_in = 1'b0;
		pd = '{default: 1'b0};
	endtask : do_reset
	task t_lanes;
		step(3, 17'h10, 36'h123456789, 0, 0, 4'hf, 1'b0, 1'b1);
		step(3, 17'h10, 36'hfffffffff, 0, 0, 4'hd, 1'b1, 1'b0);
		step(3, 17'h11, 36'habcdef012, 0, 0, 4'h0, 1'b1, 1'b0);
		step(3, 17'h10, 36'h0, 1, 36'h12347ff89, 4'h0, 1'b1, 1'b1);
		idle(6);
		chk_bit(write_post_ready_out, 1'b1, "post ready");
		step(2, 17'h10, 36'h0, 1, 36'h12347ff89);
		step(1, 17'h11, 36'h0, 1, 36'habcdef012);
		idle(4);
	endtask : t_lanes
	task t_burst(input logic o);
		do_reset(o);
		for (int i = 0; i < 4; i++)
			step(3, 17'(17'h20 + i), word(17'(17'h20 + i)), 0, 0, 4'hf, 1'b0);
		idle(6);
		step(1, 17'h21, 36'h0, 1, word(baddr(2'h1, 2'h0, o)));
		step(4, 17'h0, 36'h0, 1, word(baddr(2'h1, 2'h1, o)));
		step(5, 17'h0, 36'h0, 1, word(baddr(2'h1, 2'h1, o)));
		step(6, 17'h0, 36'h0, 1, word(baddr(2'h1, 2'h1, o)));
		step(4, 17'h0, 36'h0, 1, word(baddr(2'h1, 2'h2, o)));
		step(4, 17'h0, 36'h0, 1, word(baddr(2'h1, 2'h3, o)));
		step(2, 17'h23, 36'h0, 1, word(17'h23));
		step(4, 17'h0, 36'h0, 1, word(baddr(2'h3, 2'h1, o)));
		idle(4);
	endtask : t_burst
	task t_float;
		i_host_model.oe_off = 1'b1;
		step(1, 17'h20, 36'h0, 0, 36'h0);
		idle(4);
		i_host_model.oe_off = 1'b0;
		idle(5);
	endtask : t_float
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		do_reset(1'b0);
		t_lanes;
		$display("lanes test done");
		t_burst(1'b0);
		$display("linear burst test done");
		t_burst(1'b1);
		$display("interleaved burst test done");
		t_float;
		$display("float test done");
		give_verdict;
	end
	// Whole run needs well under 200 cycles
	initial begin
		repeat (2000) @(posedge clk_in);
		fails++;
		give_verdict;
	end
endmodule : tb_top
bind pipelined_burst_sync_sram sram_chk i_sram_chk (.clk_in, .sys_rst_in,
	.proc_addr_strobe_n_in, .ctrl_addr_strobe_n_in, .burst_advance_n_in,
	.chip_enable_primary_n_in, .chip_enable_high_in, .chip_enable_third_n_in,
	.lane_write_n_in, .all_lanes_write_n_in, .write_enable_n_in, .output_enable_n_in,
	.byte_lane_data_out, .byte_lane_data_oe_out, .write_post_ready_out);
